/* src/adc_conversion_sequencer.sv */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// [R1] three-bit channel field picks analog input zero to seven in binary order
// [R2] continuous bit set runs conversions back to back, clear stops after one
// [R3] busy flag in control bit 4 is read only, high during a conversion
// [R4] clock-output enable drives oscillator divided by twelve onto the clock pin
// [R5] baud select bit routes serial modes 1 and 3 to internal baud generator
// [R6] eight-bit result stays unchanged until the next finished conversion
// [R7] unadjusted conversion loads the result in the fifteenth machine cycle
// [R8] software may read and write the result register freely
// [R9] reference register low nibble sets lower step, high nibble upper step
// [R10] a zero nibble uses the external reference directly
// [R11] software keeps lower nibble below 13, upper above 3, four apart
// [R12] input above upper reference gives FF, below lower gives 00
// [R13] every reference register write starts a conversion, aborting a running one
// [R14] busy rises with the starting write, converting begins next machine cycle
// [R15] conversion lasts 15, 22 or 29 machine cycles by adjusted references
// [R16] input sampled for five machine cycles, then held for the rest
// [R17] at end: load result, clear busy, set irq flag, continuous restarts next
// [R18] software clears the converter irq flag; nothing clears it on its own
// [R19] all timing counts machine cycles of twelve oscillator clocks
module adc_conversion_sequencer (
   input  wire logic                       sys_clk,          // oscillator, 10 MHz
   input  wire logic                       sys_rst,          // async reset, high
   input  wire logic [11:0]                s_axi_awaddr,     // write address
   input  wire logic                       s_axi_awvalid,    // write address valid
   output logic                            s_axi_awready,    // write address ready
   input  wire logic [31:0]                s_axi_wdata,      // write data
   input  wire logic [3:0]                 s_axi_wstrb,      // byte enables
   input  wire logic                       s_axi_wvalid,     // write data valid
   output logic                            s_axi_wready,     // write data ready
   output logic [1:0]                      s_axi_bresp,      // write response
   output logic                            s_axi_bvalid,     // write response valid
   input  wire logic                       s_axi_bready,     // write response ready
   input  wire logic [11:0]                s_axi_araddr,     // read address
   input  wire logic                       s_axi_arvalid,    // read address valid
   output logic                            s_axi_arready,    // read address ready
   output logic [31:0]                     s_axi_rdata,      // read data
   output logic [1:0]                      s_axi_rresp,      // read response
   output logic                            s_axi_rvalid,     // read data valid
   input  wire logic                       s_axi_rready,     // read data ready
   output adc_seq_pkg::analog_ctrl_t       analog_ctrl,      // to sample/compare network
   input  wire adc_seq_pkg::analog_status_t analog_status,   // from comparator
   output logic                            clock_output_pin, // divided clock pin
   output logic                            baud_source_internal, // serial baud route
   output logic                            converter_irq_flag // request flag level
);
   logic [7:0]  ctrl_reg;
   logic [7:0]  refprog_reg;
   logic [7:0]  result_reg;
   logic [7:0]  sar_reg;
   logic        busy_reg;
   logic        irq_reg;
   logic [4:0]  cnt_reg;
   logic        mc_en;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [11:0] awaddr_reg;
   logic [7:0]  wbyte_reg;
   logic        wbyte_en_reg;
   logic        wr_fire;
   logic        wr_refprog;
   logic        wr_ctrl;
   logic        wr_result;
   logic        wr_irq;
   logic        done;
   logic [4:0]  total;
   logic [4:0]  settle;
   logic [4:0]  sar_pos;
   logic [2:0]  sar_idx;
   logic        lower_adj;
   logic        upper_adj;

   machine_cycle_divider u_div (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .clk_out_en (ctrl_reg[adc_seq_pkg::CTL_CLK_BIT]),
      .mc_en      (mc_en),                                     // [R19]
      .clk_out    (clock_output_pin)                           // [R4]
   );

   // write channel: address and data may arrive in either order
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 12'h000;
      end
      else if (s_axi_awvalid && !aw_held_reg)
      begin
         aw_held_reg <= 1'b1;
         awaddr_reg  <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_held_reg <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         w_held_reg   <= 1'b0;
         wbyte_reg    <= 8'h00;
         wbyte_en_reg <= 1'b0;
      end
      else if (s_axi_wvalid && !w_held_reg)
      begin
         w_held_reg   <= 1'b1;
         wbyte_reg    <= s_axi_wdata[7:0];
         wbyte_en_reg <= s_axi_wstrb[0];
      end
      else if (wr_fire)
         w_held_reg <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= adc_seq_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_reg == adc_seq_pkg::ADDR_CONTROL || awaddr_reg == adc_seq_pkg::ADDR_RESULT
             || awaddr_reg == adc_seq_pkg::ADDR_REFPROG || awaddr_reg == adc_seq_pkg::ADDR_IRQ)
            s_axi_bresp <= adc_seq_pkg::RESP_OKAY;
         else
            s_axi_bresp <= adc_seq_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   assign wr_ctrl    = wr_fire && wbyte_en_reg && awaddr_reg == adc_seq_pkg::ADDR_CONTROL;
   assign wr_result  = wr_fire && wbyte_en_reg && awaddr_reg == adc_seq_pkg::ADDR_RESULT;
   assign wr_refprog = wr_fire && wbyte_en_reg && awaddr_reg == adc_seq_pkg::ADDR_REFPROG;
   assign wr_irq     = wr_fire && wbyte_en_reg && awaddr_reg == adc_seq_pkg::ADDR_IRQ;

   // read channel: one outstanding read, answered the cycle after acceptance
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= adc_seq_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= adc_seq_pkg::RESP_OKAY;
         case (s_axi_araddr)
            adc_seq_pkg::ADDR_CONTROL:
               s_axi_rdata <= {24'h000000, ctrl_reg[7:5], busy_reg, ctrl_reg[3:0]}; // [R3]
            adc_seq_pkg::ADDR_RESULT:
               s_axi_rdata <= {24'h000000, result_reg};                          // [R8]
            adc_seq_pkg::ADDR_REFPROG:
               s_axi_rdata <= {24'h000000, refprog_reg};
            adc_seq_pkg::ADDR_IRQ:
               s_axi_rdata <= {31'h00000000, irq_reg};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= adc_seq_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // control bits; busy and the reserved bit are never stored from software
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ctrl_reg <= adc_seq_pkg::CTL_RESET;
      else if (wr_ctrl)
         ctrl_reg <= wbyte_reg & adc_seq_pkg::CTL_WR_MASK;           // [R3]
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         refprog_reg <= adc_seq_pkg::REF_RESET;
      else if (wr_refprog)
         refprog_reg <= wbyte_reg;                                   // [R9]
   end

   // reference steps use the live register, so a restart picks up the new value
   assign lower_adj = (refprog_reg[3:0] != 4'h0);                   // [R10]
   assign upper_adj = (refprog_reg[7:4] != 4'h0);                   // [R10]
   assign settle    = (lower_adj ? adc_seq_pkg::ADJ_EXTRA : 5'h00)
                    + (upper_adj ? adc_seq_pkg::ADJ_EXTRA : 5'h00);
   assign total     = adc_seq_pkg::CONV_BASE + settle;                // [R15]
   assign done      = mc_en && busy_reg && !wr_refprog && cnt_reg == total; // [R7]

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_reg <= 1'b0;
         cnt_reg  <= 5'h00;
      end
      else if (wr_refprog)
      begin
         busy_reg <= 1'b1;                                           // [R13] [R14]
         cnt_reg  <= 5'h00;
      end
      else if (done)
      begin
         busy_reg <= ctrl_reg[adc_seq_pkg::CTL_MODE_BIT];           // [R2] [R17]
         cnt_reg  <= 5'h00;
      end
      else if (mc_en && busy_reg)
         cnt_reg <= cnt_reg + 5'h01;                                 // [R14] [R19]
   end

   // trial bits start after sampling and any reference settling time
   assign sar_pos = cnt_reg - adc_seq_pkg::SAMPLE_CYC - settle;
   assign sar_idx = 3'(adc_seq_pkg::SAR_BITS - sar_pos);

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         sar_reg <= adc_seq_pkg::SAR_FIRST;
      else if (wr_refprog || done)
         sar_reg <= adc_seq_pkg::SAR_FIRST;
      else if (mc_en && busy_reg && cnt_reg > adc_seq_pkg::SAMPLE_CYC + settle
               && sar_pos <= adc_seq_pkg::SAR_BITS)
      begin
         sar_reg[sar_idx] <= analog_status.cmp_above;
         if (sar_idx != 3'h0)
            sar_reg[sar_idx - 3'h1] <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         result_reg <= adc_seq_pkg::RES_RESET;
      else if (done && analog_status.above_upper)
         result_reg <= adc_seq_pkg::RES_FULL;                        // [R12]
      else if (done && analog_status.below_lower)
         result_reg <= adc_seq_pkg::RES_ZERO;                        // [R12]
      else if (done)
         result_reg <= sar_reg;                                      // [R6] [R17]
      else if (wr_result)
         result_reg <= wbyte_reg;                                    // [R8]
   end

   // a finishing conversion wins over a software clear in the same cycle
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq_reg <= 1'b0;
      else if (done)
         irq_reg <= 1'b1;                                            // [R17]
      else if (wr_irq)
         irq_reg <= wbyte_reg[0];                                    // [R18]
   end

   assign converter_irq_flag         = irq_reg;
   assign baud_source_internal       = ctrl_reg[adc_seq_pkg::CTL_BAUD_BIT]; // [R5]
   assign analog_ctrl.channel        = ctrl_reg[2:0];                // [R1]
   assign analog_ctrl.sampling       = busy_reg && cnt_reg != 5'h00
                                     && cnt_reg <= adc_seq_pkg::SAMPLE_CYC; // [R16]
   assign analog_ctrl.trial_code     = sar_reg;
   assign analog_ctrl.lower_step     = refprog_reg[3:0];             // [R9]
   assign analog_ctrl.upper_step     = refprog_reg[7:4];             // [R9]
   assign analog_ctrl.lower_adjust   = lower_adj;                    // [R10]
   assign analog_ctrl.upper_adjust   = upper_adj;                    // [R10]

   sequence seq_start;
      wr_refprog;
   endsequence

   sequence seq_finish;
      done;
   endsequence

   a_busy_on_start : assert property (@(posedge sys_clk) disable iff (sys_rst)
      seq_start |=> busy_reg && cnt_reg == 5'h00) else $error("busy not set by start"); // [R14]
   a_single_stop : assert property (@(posedge sys_clk) disable iff (sys_rst)
      seq_finish ##0 !ctrl_reg[3] |=> !busy_reg) else $error("single mode kept running"); // [R2]
   a_cont_restart : assert property (@(posedge sys_clk) disable iff (sys_rst)
      seq_finish ##0 ctrl_reg[3] |=> busy_reg) else $error("continuous mode stopped"); // [R17]
   a_conv_length : assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
      seq_finish |-> cnt_reg == (refprog_reg == 8'h00 ? 5'h0F
         : (refprog_reg[3:0] == 4'h0 || refprog_reg[7:4] == 4'h0) ? 5'h16 : 5'h1D))
      else $error("bad length");
   a_irq_on_done : assert property (@(posedge sys_clk) disable iff (sys_rst)
      seq_finish |=> converter_irq_flag) else $error("irq flag not set at end"); // [R17]
   a_result_hold : assert property (@(posedge sys_clk) disable iff (sys_rst)
      !done && !wr_result |=> $stable(result_reg)) else $error("result changed unasked"); // [R6]
   a_sat_high : assert property (@(posedge sys_clk) disable iff (sys_rst)
      seq_finish ##0 analog_status.above_upper |=> result_reg == 8'hFF) else $error("no FF"); // [R12]
   a_sample_window : assert property (@(posedge sys_clk) disable iff (sys_rst)
      analog_ctrl.sampling |-> busy_reg && cnt_reg <= 5'h05) else $error("sampling too long"); // [R16]
   a_busy_readback : assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == adc_seq_pkg::ADDR_CONTROL
      |=> s_axi_rdata[4] == $past(busy_reg)) else $error("busy bit misreported"); // [R3]
   a_channel_route : assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_ctrl |=> analog_ctrl.channel == $past(wbyte_reg[2:0])) else $error("channel wrong"); // [R1]

endmodule : adc_conversion_sequencer

/* common/adc_seq_pkg.sv */
package adc_seq_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_CONTROL   = 8'hD8;
   localparam logic [7:0]  IDX_RESULT    = 8'hD9;
   localparam logic [7:0]  IDX_REFPROG   = 8'hDA;
   localparam logic [7:0]  IDX_IRQ       = 8'hDB;
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] ADDR_CONTROL  = {2'h0, IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_RESULT   = {2'h0, IDX_RESULT, 2'h0};
   localparam logic [11:0] ADDR_REFPROG  = {2'h0, IDX_REFPROG, 2'h0};
   localparam logic [11:0] ADDR_IRQ      = {2'h0, IDX_IRQ, 2'h0};

   // control register fields
   localparam int          CTL_MODE_BIT  = 3;
   localparam int          CTL_BUSY_BIT  = 4;
   localparam int          CTL_CLK_BIT   = 6;
   localparam int          CTL_BAUD_BIT  = 7;
   localparam logic [7:0]  CTL_WR_MASK   = 8'hCF;
   localparam logic [7:0]  CTL_RESET     = 8'h00;
   localparam logic [7:0]  REF_RESET     = 8'h00;
   localparam logic [7:0]  RES_RESET     = 8'h00;
   localparam logic [7:0]  RES_FULL      = 8'hFF;
   localparam logic [7:0]  RES_ZERO      = 8'h00;
   localparam logic [7:0]  SAR_FIRST     = 8'h80;

   // machine cycle and conversion timing, in oscillator clocks / machine cycles
   localparam int          OSC_PER_MC    = 12;
   localparam int          CLK_HIGH_CNT  = 6;
   localparam logic [4:0]  CONV_BASE     = 5'h0F;
   localparam logic [4:0]  ADJ_EXTRA     = 5'h07;
   localparam logic [4:0]  SAMPLE_CYC    = 5'h05;
   localparam logic [4:0]  SAR_BITS      = 5'h08;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [2:0] channel;
      logic       sampling;
      logic [7:0] trial_code;
      logic [3:0] lower_step;
      logic [3:0] upper_step;
      logic       lower_adjust;
      logic       upper_adjust;
   } analog_ctrl_t;

   typedef struct packed {
      logic       cmp_above;
      logic       above_upper;
      logic       below_lower;
   } analog_status_t;

endpackage : adc_seq_pkg

/* src/machine_cycle_divider.sv */
`timescale 1ns/1ps
module machine_cycle_divider #(
   parameter int DIV  = adc_seq_pkg::OSC_PER_MC,
   parameter int HIGH = adc_seq_pkg::CLK_HIGH_CNT
) (
   input  wire logic sys_clk,    // oscillator clock
   input  wire logic sys_rst,    // async reset, active high
   input  wire logic clk_out_en, // gate for the divided clock pin
   output logic      mc_en,      // one pulse per machine cycle
   output logic      clk_out     // divided clock, registered
);
   logic [3:0] div_reg;

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         div_reg <= 4'h0;
      else if (div_reg == 4'(DIV - 1))
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end

   assign mc_en = (div_reg == 4'(DIV - 1));

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         clk_out <= 1'b0;
      else
         clk_out <= clk_out_en && (div_reg < 4'(HIGH)); // [R4]
   end

   a_clock_output_pin_gated : assert property (@(posedge sys_clk) disable iff (sys_rst)
      !clk_out_en |=> !clk_out) else $error("clock output runs while disabled"); // [R4]
   a_mc_period : assert property (@(posedge sys_clk) disable iff (sys_rst)
      mc_en |=> !mc_en [*8] ##0 1) else $error("machine cycle pulse too close"); // [R19]

endmodule : machine_cycle_divider

/* verif/analog_front_model.sv */
`timescale 1ns/1ps
module analog_front_model (
   input  wire logic                        sys_clk,       // oscillator clock
   input  wire adc_seq_pkg::analog_ctrl_t   analog_ctrl,   // from the sequencer
   input  wire logic [63:0]                 input_levels,  // eight input codes, byte each
   output adc_seq_pkg::analog_status_t      analog_status  // comparator results
);
   logic [7:0] held_level;

   // the capacitor follows the input only while sampling; later input moves are not seen
   always_ff @(posedge sys_clk)
   begin
      if (analog_ctrl.sampling)
      begin
         held_level <= input_levels[{analog_ctrl.channel, 3'h0} +: 8];
      end
   end

   always_comb
   begin
      analog_status.cmp_above   = held_level >= analog_ctrl.trial_code;
      analog_status.above_upper = analog_ctrl.upper_adjust
                                  && held_level > {analog_ctrl.upper_step, 4'h0};
      analog_status.below_lower = analog_ctrl.lower_adjust
                                  && held_level < {analog_ctrl.lower_step, 4'h0};
   end
endmodule : analog_front_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic                        sys_clk;
   logic                        sys_rst;
   logic [11:0]                 s_axi_awaddr, s_axi_araddr;
   logic [31:0]                 s_axi_wdata, s_axi_rdata;
   logic [1:0]                  s_axi_bresp, s_axi_rresp, resp_seen;
   logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                        s_axi_rvalid, s_axi_rready;
   adc_seq_pkg::analog_ctrl_t   analog_ctrl;
   adc_seq_pkg::analog_status_t analog_status;
   logic                        clock_output_pin, baud_source_internal, converter_irq_flag;
   logic [63:0]                 input_levels;
   logic [7:0]                  rd_byte, last_result;
   time                         t_taken, t_a, t_b;
   int                          errors, comparisons, highs;

   adc_conversion_sequencer i_adc_conversion_sequencer (
      .sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_ctrl, .analog_status,
      .clock_output_pin, .baud_source_internal, .converter_irq_flag);

   analog_front_model i_analog_front_model (
      .sys_clk, .analog_ctrl, .input_levels, .analog_status);

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check_byte(input string what, input logic [7:0] expv, input logic [7:0] got);
      comparisons++;
      if (got !== expv)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, expv, got);
      end
   endtask : check_byte

   task automatic check_range(input string what, input int lo, input int hi, input int got);
      comparisons++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
      end
   endtask : check_range

   // address and data are offered together and each is dropped at its own taking edge
   task automatic reg_write(input logic [11:0] addr, input logic [7:0] data);
      int n;
      bit aw_hit, w_hit, aw_done, w_done;
      @(posedge sys_clk);
      s_axi_awaddr  <= addr;
      s_axi_wdata   <= {24'h000000, data};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      n = 0;
      while (!(aw_done && w_done) && n < 50)
      begin
         @(negedge sys_clk);
         aw_hit = !aw_done && s_axi_awready === 1'b1;
         w_hit = !w_done && s_axi_wready === 1'b1;
         @(posedge sys_clk);
         if (aw_hit)
            s_axi_awvalid <= 1'b0;
         if (w_hit)
            s_axi_wvalid <= 1'b0;
         if (aw_hit || w_hit)
            t_taken = $time;
         aw_done |= aw_hit;
         w_done |= w_hit;
         n++;
      end
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (s_axi_bvalid !== 1'b1 && n < 100);
      resp_seen = s_axi_bresp;
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
      check_range("write handshake", 2, 99, n);
   endtask : reg_write

   task automatic reg_read(input logic [11:0] addr);
      int n;
      @(posedge sys_clk);
      s_axi_araddr  <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (s_axi_arready !== 1'b1 && n < 50);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (s_axi_rvalid !== 1'b1 && n < 100);
      rd_byte = s_axi_rdata[7:0];
      resp_seen = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
      check_range("read handshake", 2, 99, n);
   endtask : reg_read

   // returns the clock edge at which the request flag rose
   task automatic wait_irq(output time t);
      int n;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (converter_irq_flag !== 1'b1 && n < 1000);
      t = $time - 50;
      check_range("irq wait", 1, 999, n);
   endtask : wait_irq

   task automatic count_clock(input int n);
      repeat (24) @(posedge sys_clk);
      highs = 0;
      repeat (n)
      begin
         @(negedge sys_clk);
         highs += int'(clock_output_pin === 1'b1);
      end
   endtask : count_clock

   task automatic convert(input logic [2:0] ch, input logic [7:0] ref_val, input logic [7:0] lvl,
                          input logic [7:0] expv, input int ncyc, input bit abort);
      input_levels[{ch, 3'h0} +: 8] <= lvl;
      reg_write(adc_seq_pkg::ADDR_CONTROL, {5'h00, ch});
      if (abort)
         reg_write(adc_seq_pkg::ADDR_REFPROG, ref_val);
      repeat (abort ? 60 : 0) @(posedge sys_clk);
      reg_write(adc_seq_pkg::ADDR_REFPROG, ref_val);
      t_a = t_taken;
      reg_read(adc_seq_pkg::ADDR_CONTROL);
      check_byte("busy after start", {5'h02, ch}, rd_byte);
      reg_read(adc_seq_pkg::ADDR_RESULT);
      check_byte("result during conversion", last_result, rd_byte);
      repeat (100) @(posedge sys_clk);
      // a moved input after the sampling window must not reach the result
      input_levels[{ch, 3'h0} +: 8] <= ~lvl;
      wait_irq(t_b);
      // taken edge, one clock to the start edge, up to one machine cycle to the first boundary
      check_range("conversion cycles", ncyc * 12 + 2, ncyc * 12 + 13,
                  int'((t_b - t_a) / 100));
      reg_read(adc_seq_pkg::ADDR_RESULT);
      check_byte("result", expv, rd_byte);
      reg_read(adc_seq_pkg::ADDR_CONTROL);
      check_byte("busy after end", {5'h00, ch}, rd_byte);
      reg_write(adc_seq_pkg::ADDR_IRQ, 8'h00);
      check_byte("irq flag cleared", 8'h00, {7'h00, converter_irq_flag});
      last_result = expv;
   endtask : convert

   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial
   begin
      #3000000;
      errors++;
      $display("unexpected run length: expected end of tests, seen watchdog");
      report_and_stop();
   end

   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, input_levels} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      errors = 0;
      comparisons = 0;
      last_result = 8'hA5;
      sys_rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         reg_read(adc_seq_pkg::ADDR_CONTROL + 12'(4 * i));
         check_byte("reset value", 8'h00, rd_byte);
      end
      reg_write(adc_seq_pkg::ADDR_RESULT, 8'hA5);
      reg_read(adc_seq_pkg::ADDR_RESULT);
      check_byte("result storage", 8'hA5, rd_byte);
      reg_write(adc_seq_pkg::ADDR_CONTROL, 8'hFF);
      reg_read(adc_seq_pkg::ADDR_CONTROL);
      check_byte("control readback", 8'hCF, rd_byte);
      check_byte("channel select", 8'h07, {5'h00, analog_ctrl.channel});
      check_byte("baud route", 8'h01, {7'h00, baud_source_internal});
      count_clock(120);
      check_range("clock pin highs", 60, 60, highs);
      reg_write(adc_seq_pkg::ADDR_CONTROL, 8'h00);
      check_byte("baud route", 8'h00, {7'h00, baud_source_internal});
      count_clock(24);
      check_range("clock pin highs", 0, 0, highs);
      reg_read(12'h100);
      check_byte("unmapped read", {6'h00, adc_seq_pkg::RESP_SLVERR}, {6'h00, resp_seen});
      reg_write(12'h100, 8'h5A);
      check_byte("unmapped write", {6'h00, adc_seq_pkg::RESP_SLVERR}, {6'h00, resp_seen});
      for (int c = 0; c < 8; c++)
      begin
         convert(3'(c), 8'h00, 8'(c * 29 + 12), 8'(c * 29 + 12), 15, 1'b0);
      end
      convert(3'h2, 8'h05, 8'h20, adc_seq_pkg::RES_ZERO, 22, 1'b1);
      convert(3'h5, 8'hA0, 8'hF0, adc_seq_pkg::RES_FULL, 22, 1'b0);
      convert(3'h6, 8'hA3, 8'h77, 8'h77, 29, 1'b1);
      input_levels[7:0] <= 8'h3C;
      reg_write(adc_seq_pkg::ADDR_CONTROL, 8'h08);
      reg_write(adc_seq_pkg::ADDR_REFPROG, 8'h00);
      wait_irq(t_a);
      reg_write(adc_seq_pkg::ADDR_IRQ, 8'h00);
      wait_irq(t_b);
      // restart cycle plus fifteen conversion cycles per period
      check_range("continuous period", 192, 192, int'((t_b - t_a) / 100));
      reg_read(adc_seq_pkg::ADDR_CONTROL);
      check_byte("busy while continuous", 8'h18, rd_byte);
      reg_write(adc_seq_pkg::ADDR_CONTROL, 8'h00);
      reg_write(adc_seq_pkg::ADDR_IRQ, 8'h00);
      wait_irq(t_a);
      check_range("last period", 192, 192, int'((t_a - t_b) / 100));
      reg_write(adc_seq_pkg::ADDR_IRQ, 8'h00);
      repeat (400) @(posedge sys_clk);
      check_byte("irq after stop", 8'h00, {7'h00, converter_irq_flag});
      reg_read(adc_seq_pkg::ADDR_RESULT);
      check_byte("held result", 8'h3C, rd_byte);
      report_and_stop();
   end
endmodule : tb_top
